// [logic/sas_pkg.sv]
// sas_pkg: constants and types shared by the sar sequencer files
// assumes a single 10 MHz clock domain
package sas_pkg;
   localparam int          SAS_BITS       = 12;           // result width
   localparam int          SAS_CLK_NS     = 100;          // system clock period
   localparam int          SAS_LONG_NS    = 800;          // long trial period, least time
   localparam int          SAS_SHORT_NS   = 400;          // short trial period, least time
   localparam int          SAS_LONG_CYC   = (SAS_LONG_NS + SAS_CLK_NS - 1) / SAS_CLK_NS;
   localparam int          SAS_SHORT_CYC  = (SAS_SHORT_NS + SAS_CLK_NS - 1) / SAS_CLK_NS;
   localparam int          SAS_LONG_CNT   = 3;            // periods stretched at start
   localparam logic [3:0]  SAS_TMR_W_ONE  = 4'h1;
   localparam logic [3:0]  SAS_LONG_LOAD  = 4'(SAS_LONG_CYC - 1);
   localparam logic [3:0]  SAS_SHORT_LOAD = 4'(SAS_SHORT_CYC - 1);
   localparam logic [11:0] SAS_MSB_CODE   = 12'h0800;
   localparam logic [11:0] SAS_ZERO_CODE  = 12'h0000;
   localparam logic [3:0]  SAS_TOP_IDX    = 4'hb;
   localparam logic [3:0]  SAS_IDX_ZERO   = 4'h0;

   typedef enum logic [1:0] {
      SAS_IDLE = 2'b00,
      SAS_TRY  = 2'b01,
      SAS_DONE = 2'b10
   } sas_state_t;
endpackage

// [logic/sas_tick_if.sv]
// sas_tick_if: carries the trial pacing between sequencer and timer
// assumes both ends on the same clock
`timescale 1ns/1ns
interface sas_tick_if;
   logic       start;   // load timer for a new period
   logic       long_sel;// period is a stretched one
   logic       tick;    // period has ended
   modport seq (output start, output long_sel, input tick);
   modport tmr (input start, input long_sel, output tick);
endinterface

// [logic/sas_timer.sv]
// sas_timer: counts one trial period, long or short
// assumes start is a one-cycle pulse from the sequencer
`timescale 1ns/1ns
module sas_timer
   import sas_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // pacing
   sas_tick_if.tmr  tk
);
   typedef struct packed {
      logic [3:0] cnt;
      logic       run;
      logic       tick;
   } sas_tmr_t;

   sas_tmr_t st;
   sas_tmr_t next_st;

   // reload on start, count down, pulse at zero
   always_comb begin
      next_st      = st;
      next_st.tick = 1'b0;
      if (tk.start) begin
         next_st.cnt = tk.long_sel ? SAS_LONG_LOAD : SAS_SHORT_LOAD;
         next_st.run = 1'b1;
      end else if (st.run) begin
         if (st.cnt == SAS_IDX_ZERO) begin
            next_st.run  = 1'b0;
            next_st.tick = 1'b1;
         end else begin
            next_st.cnt = st.cnt - SAS_TMR_W_ONE;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tk.tick = st.tick;
endmodule

// [logic/sas_seq.sv]
// sas_seq: 12-bit successive-approximation sequencer
// assumes an external dac, comparator and sample-and-hold, all analogue
// How it works
// - start drives msb only to the dac
// - comparator high keeps trial bit, else clears
// - repeat downward for eleven lower bits
// - first three trial periods are longer
// - zero input: code starts and ends zero
// - hold/convert asserted during every conversion
`timescale 1ns/1ns
module sas_seq
   import sas_pkg::*;
(
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  nrst,
   // control
   input  wire logic                  conv_start,
   // analogue side
   input  wire logic                  cmp_above,
   output logic [SAS_BITS-1:0]        dac_code,
   output logic                       hold,
   // result
   output logic [SAS_BITS-1:0]        result,
   output logic                       done,
   output logic                       busy
);
   import sas_pkg::*;

   typedef struct packed {
      sas_state_t       fsm;
      logic [11:0]      code;
      logic [3:0]       idx;
      logic [11:0]      res;
      logic             done;
      logic             hold;
      logic [2:0]       cmp_sync;
      logic             cmp;
      logic             start;
      logic             long_sel;
      logic             busy;
   } sas_seq_t;

   sas_seq_t st;
   sas_seq_t next_st;
   sas_tick_if tk ();

   // comparator crosses from the analogue world, filtered by agreement
   logic cmp_agree;
   assign cmp_agree = (st.cmp_sync[1] == st.cmp_sync[2]);

   // sequencing: one bit per timer period, msb first
   always_comb begin
      next_st          = st;
      next_st.done     = 1'b0;
      next_st.start    = 1'b0;
      next_st.cmp_sync = {st.cmp_sync[1:0], cmp_above};
      if (cmp_agree) begin
         next_st.cmp = st.cmp_sync[2];
      end
      case (st.fsm)
         SAS_IDLE: begin
            next_st.code = SAS_ZERO_CODE;
            if (conv_start) begin
               next_st.fsm      = SAS_TRY;
               next_st.code     = SAS_MSB_CODE;
               next_st.idx      = SAS_TOP_IDX;
               next_st.hold     = 1'b1;
               next_st.start    = 1'b1;
               next_st.long_sel = 1'b1;
            end
         end
         SAS_TRY: begin
            if (tk.tick) begin
               // decide the bit under trial
               next_st.code[st.idx] = st.cmp;
               if (st.idx == SAS_IDX_ZERO) begin
                  next_st.fsm  = SAS_DONE;
               end else begin
                  next_st.idx                 = st.idx - SAS_TMR_W_ONE;
                  next_st.code[st.idx - 4'h1] = 1'b1;
                  next_st.start               = 1'b1;
                  // idx still counts trials started; long for msb and next two
                  next_st.long_sel = (st.idx > (SAS_TOP_IDX - 4'(SAS_LONG_CNT - 1)));
               end
            end
         end
         SAS_DONE: begin
            next_st.res  = st.code;
            next_st.done = 1'b1;
            next_st.hold = 1'b0;
            next_st.code = SAS_ZERO_CODE;
            next_st.fsm  = SAS_IDLE;
         end
         default: begin
            next_st.fsm = SAS_IDLE;
         end
      endcase
      // busy registered from the next state so the pin comes off a flop
      next_st.busy = (next_st.fsm != SAS_IDLE);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // pacing timer
   assign tk.start    = st.start;
   assign tk.long_sel = st.long_sel;

   sas_timer u_tmr (
      .clk  (clk),
      .nrst (nrst),
      .tk   (tk)
   );

   // outputs straight from state flops
   assign dac_code = st.code;
   assign hold     = st.hold;
   assign result   = st.res;
   assign done     = st.done;
   assign busy     = st.busy;

   // checks
   a_msb_first: assert property (@(posedge clk) disable iff (!nrst)
      (st.fsm == SAS_IDLE && conv_start) |=> dac_code == SAS_MSB_CODE)
      else $error("conversion did not start with msb only");
   a_bit_decide: assert property (@(posedge clk) disable iff (!nrst)
      (st.fsm == SAS_TRY && tk.tick) |=> dac_code[$past(st.idx)] == $past(st.cmp))
      else $error("trial bit not set by comparator");
   a_zero_idle: assert property (@(posedge clk) disable iff (!nrst)
      (st.fsm == SAS_IDLE && !$past(conv_start)) |-> dac_code == SAS_ZERO_CODE)
      else $error("dac code not zero when idle");
   a_hold_busy: assert property (@(posedge clk) disable iff (!nrst)
      (st.fsm == SAS_TRY) |-> hold)
      else $error("hold low during trials");
   a_done_pulse: assert property (@(posedge clk) disable iff (!nrst)
      done |=> !done)
      else $error("done longer than one cycle");
   a_done_result: assert property (@(posedge clk) disable iff (!nrst)
      $rose(done) |-> result == $past(dac_code))
      else $error("result differs from final code");
   a_long_first: assert property (@(posedge clk) disable iff (!nrst)
      (st.fsm == SAS_IDLE && conv_start) |=> ##1 !tk.tick [*7])
      else $error("first period not stretched");
   a_short_last: assert property (@(posedge clk) disable iff (!nrst)
      (tk.start && !tk.long_sel) |=> ##[1:5] tk.tick)
      else $error("short period too long");
   a_conv_len: assert property (@(posedge clk) disable iff (!nrst)
      (st.fsm == SAS_IDLE && conv_start) |=> ##[84:86] done)
      else $error("conversion length wrong");

   c_conv:  cover property (@(posedge clk) done);
   c_full:  cover property (@(posedge clk) done && result == 12'hfff);
   c_zero:  cover property (@(posedge clk) done && result == 12'h0000);
   c_back:  cover property (@(posedge clk) done ##1 busy);
endmodule

// [verification/sas_analog_model.sv]
// sas_analog_model: sample-and-hold, dac and comparator behind the sequencer
// assumes the bench sets level before hold rises
`timescale 1ns/1ns
module sas_analog_model (
   // clock
   input  wire logic        clk,
   // analogue side
   input  wire logic        hold,
   input  wire logic [11:0] dac_code,
   input  wire logic [12:0] level,
   output logic             cmp_above
);
   logic [12:0] held;
   logic        hold_d;
   initial begin
      held = 13'h0000;
      hold_d = 1'b0;
      cmp_above = 1'b0;
   end
   // capture on hold rising; comparator lags a clock, as a real one would
   always @(posedge clk) begin
      hold_d <= hold;
      if (hold && !hold_d) held <= level;
      cmp_above <= (held > {1'b0, dac_code});
   end
endmodule

// [verification/test_sar_adc_sequencer.sv]
// test_sar_adc_sequencer: drives conversions through the sequencer
// assumes the analogue model answers strictly above as a kept bit
`timescale 1ns/1ns
module test_sar_adc_sequencer;
   import sas_pkg::*;
   logic                clk = 1'b0;
   logic                nrst = 1'b0;
   logic                conv_start = 1'b0;
   logic                cmp_above, hold, done, busy;
   logic [SAS_BITS-1:0] dac_code, result;
   logic [12:0]         level = 13'h0000;
   int                  miscompares = 0;
   int                  comparisons = 0;
   always #50 clk = ~clk;
   sas_seq i_dut (.clk(clk), .nrst(nrst), .conv_start(conv_start), .cmp_above(cmp_above),
      .dac_code(dac_code), .hold(hold), .result(result), .done(done), .busy(busy));
   sas_analog_model i_far (.clk(clk), .hold(hold), .dac_code(dac_code), .level(level),
      .cmp_above(cmp_above));
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      comparisons++;
      if (seen !== want) begin
         miscompares++;
         $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic wrap_up();
      if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // one conversion; poke retriggers mid-run, which must be ignored
   task automatic convert(input logic [12:0] v, input bit poke);
      int          n, k;
      int          t [1:13];
      logic [11:0] prev, want;
      n = 0;
      k = 0;
      prev = 12'h000;
      want = (v == 13'h0000) ? 12'h000 : 12'(v - 13'h0001);
      level = v;
      check(dac_code, 16'h0000);
      conv_start = 1'b1;
      while (done !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
         conv_start = (poke && n == 20);
         if (n > 2 && done !== 1'b1) begin
            check(hold, 1'b1);
            check(busy, 1'b1);
         end
         if (dac_code !== prev && done !== 1'b1 && k < 13) begin
            k++;
            t[k] = n;
            prev = dac_code;
            if (k == 1) check(dac_code, SAS_MSB_CODE);
         end
      end
      if (n >= 200) begin
         miscompares++;
         wrap_up();
      end
      check(result, want);
      // a cleared last bit moves the code once more than a kept one
      check(16'(k), want[0] ? 16'h000c : 16'h000d);
      check(16'(t[2] - t[1]), 16'(t[4] - t[3]));
      check(16'(t[4] - t[3] > t[5] - t[4]), 16'h0001);
      check(dac_code, 16'h0000);
      check(hold, 1'b0);
      check(busy, 1'b0);
      @(negedge clk);
      check(done, 1'b0);
      check(result, want);
   endtask
   // back to back conversions, boundary levels and a retrigger
   initial begin
      repeat (8) @(negedge clk);
      nrst = 1'b1;
      convert(13'h0000, 1'b0);
      convert(13'h1000, 1'b0);
      convert(13'h0800, 1'b1);
      convert(13'h0a5b, 1'b0);
      convert(13'h0001, 1'b0);
      wrap_up();
   end
endmodule
